//--- hdl/prs_pkg.sv
// Constants and types for the reference switchover and reconfiguration block
package prs_pkg;
  // ****************************************
  // Switchover modes
  // ****************************************
  typedef enum logic [1:0] {
    PRS_MODE_AUTO     = 2'h0,
    PRS_MODE_OVERRIDE = 2'h1,
    PRS_MODE_MANUAL   = 2'h2
  } prs_mode_e;

  // Switch sequence states, one bit changes from RUN to GATE and from GATE to MOVE
  typedef enum logic [1:0] {
    PRS_ST_RUN    = 2'h0,
    PRS_ST_GATE   = 2'h1,
    PRS_ST_MOVE   = 2'h3
  } prs_state_e;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] PRS_ADDR_CTRL    = 4'h0;  // [1:0] mode, [2] apply
  localparam logic [3:0] PRS_ADDR_STATUS  = 4'h1;  // [0] in_use [1] lost_pri [2] lost_bak [3] busy [4] waiting
  localparam logic [3:0] PRS_ADDR_SCAN    = 4'h2;  // [0] serial data bit, write shifts one bit
  localparam logic [3:0] PRS_ADDR_PRE     = 4'h3;
  localparam logic [3:0] PRS_ADDR_FB      = 4'h4;
  localparam logic [3:0] PRS_ADDR_OUT0    = 4'h5;  // 5..9 output dividers 0..4
  localparam logic [3:0] PRS_ADDR_PUMP    = 4'ha;
  localparam logic [3:0] PRS_ADDR_FILT    = 4'hb;  // [7:0] resistor, [15:8] capacitor
  localparam logic [3:0] PRS_ADDR_CHAIN   = 4'hc;  // cascade mask, read only

  localparam int PRS_CTRL_APPLY_BIT = 2;
  localparam logic [1:0] PRS_MODE_RESET = 2'h0;

  // ****************************************
  // Scan chain layout, field order pre, fb, out0..4, pump, r, c
  // ****************************************
  localparam int PRS_DIV_W   = 9;   // Divider field width, up to 511
  localparam int PRS_PUMP_W  = 3;
  localparam int PRS_FILT_W  = 8;
  localparam int PRS_N_OUT   = 5;
  localparam int PRS_SCAN_LEN = 7 * PRS_DIV_W + PRS_PUMP_W + 2 * PRS_FILT_W;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PRS_CLK_MHZ      = 100;
  localparam int PRS_SCAN_MAX_MHZ = 100;
  // Scan clock period in sys_clk cycles, rounded up so the scan rate stays at or below the limit
  localparam int PRS_SCAN_DIV = (PRS_CLK_MHZ + PRS_SCAN_MAX_MHZ - 1) / PRS_SCAN_MAX_MHZ;
  localparam int PRS_LOST_PERIODS = 2;   // Reference periods of silence that mark a lost clock
  localparam int PRS_HOLD_PERIODS = 3;   // Reference periods a switch request must stay high
  localparam logic [7:0] PRS_REF_PERIOD_RESET = 8'h04; // Nominal reference period in sys_clk cycles
endpackage

//--- hdl/prs_ref_switch.sv
// Reference switchover state machine, lost-clock sense and reconfiguration scan chain
`timescale 1ns/1ns
module prs_ref_switch #(
  parameter int         SCAN_LEN     = prs_pkg::PRS_SCAN_LEN,
  parameter logic [4:0] CASCADE_MASK = 5'h00   // Bit i: output i feeds output i+1, fixed by image
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        ref_clk_primary,
  input  wire logic        ref_clk_backup,
  input  wire logic        switch_req,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             in_use,
  output logic             lost_primary,
  output logic             lost_backup,
  output logic             mux_gate,
  output logic             pll_reset_hint,
  output logic      [44:0] output_dividers,
  output logic      [4:0]  cascade_out
);
  localparam int DW = prs_pkg::PRS_DIV_W;
  localparam int PW = prs_pkg::PRS_PUMP_W;
  localparam int FW = prs_pkg::PRS_FILT_W;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]             s_pri;      // Two sync stages plus edge history
    logic [2:0]             s_bak;
    logic [2:0]             s_req;
    logic [7:0]             sil_pri;    // Cycles since last primary falling edge
    logic [7:0]             sil_bak;
    logic [7:0]             per_pri;    // Measured primary period
    logic [7:0]             per_bak;
    logic [1:0]             cal_p;      // Falling edges seen since reset, saturating shift
    logic [1:0]             cal_b;
    logic [7:0]             hold_cnt;   // Cycles request has stayed high
    logic                   req_armed;  // Rising edge seen, hold in progress
    logic                   req_used;   // Manual swap already taken for this high level
    logic [1:0]             mode;
    prs_pkg::prs_state_e    st;
    logic                   sel;        // 0 primary, 1 backup
    logic                   gate;
    logic                   lost_p;
    logic                   lost_b;
    logic                   rst_hint;
    logic [SCAN_LEN-1:0]    scan;
    logic [DW-1:0]          pre_div;
    logic [DW-1:0]          fb_div;
    logic [5*DW-1:0]        out_div;    // Active output divider values
    logic [5*DW-1:0]        pend_div;   // Values waiting for their count boundary
    logic [4:0]             pend;
    logic [5*DW-1:0]        cnt;        // Output divider counters
    logic [PW-1:0]          pump;
    logic [FW-1:0]          filt_r;
    logic [FW-1:0]          filt_c;
    logic [31:0]            rdata;
  } prs_state_s;

  prs_state_s st_reg;
  prs_state_s st_next;

  logic pri_fall;
  logic bak_fall;
  logic req_rise;
  logic tgt_ok;
  logic [7:0] lost_lim_p;
  logic [7:0] lost_lim_b;
  logic [7:0] hold_lim;

  // Edge and limit decode from the synchronised inputs
  // Edges come from the second and third stages only, so the first stage,
  // which may still be settling, never reaches any logic
  always_comb begin
    pri_fall   = st_reg.s_pri[2] & ~st_reg.s_pri[1];
    bak_fall   = st_reg.s_bak[2] & ~st_reg.s_bak[1];
    req_rise   = ~st_reg.s_req[2] & st_reg.s_req[1];
    lost_lim_p = 8'(prs_pkg::PRS_LOST_PERIODS) * st_reg.per_pri;
    lost_lim_b = 8'(prs_pkg::PRS_LOST_PERIODS) * st_reg.per_bak;
    hold_lim   = 8'(prs_pkg::PRS_HOLD_PERIODS) *
                 ((st_reg.per_pri > st_reg.per_bak) ? st_reg.per_pri : st_reg.per_bak);
    tgt_ok     = st_reg.sel ? ~st_reg.lost_p : ~st_reg.lost_b;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic want;
    logic auto_ok;
    want = 1'b0;
    auto_ok = 1'b0;
    st_next = st_reg;
    // Two flip-flops before use, third stage only for edge history
    st_next.s_pri = {st_reg.s_pri[1:0], ref_clk_primary};
    st_next.s_bak = {st_reg.s_bak[1:0], ref_clk_backup};
    st_next.s_req = {st_reg.s_req[1:0], switch_req};

    // Silence counters and period measurement on each falling edge
    // The first falling edge after reset only opens the measurement, as the count
    // before it started at reset and not at an edge; the second gives a true period
    st_next.sil_pri = (st_reg.sil_pri == 8'hff) ? st_reg.sil_pri : st_reg.sil_pri + 8'h01;
    st_next.sil_bak = (st_reg.sil_bak == 8'hff) ? st_reg.sil_bak : st_reg.sil_bak + 8'h01;
    if (pri_fall) begin
      st_next.sil_pri = 8'h00;
      st_next.cal_p   = {st_reg.cal_p[0], 1'b1};
      // A period spanning a silence would poison the limit, so the old one is kept
      if (!st_reg.lost_p && st_reg.cal_p[0]) st_next.per_pri = st_reg.sil_pri + 8'h01;
    end
    if (bak_fall) begin
      st_next.sil_bak = 8'h00;
      st_next.cal_b   = {st_reg.cal_b[0], 1'b1};
      if (!st_reg.lost_b && st_reg.cal_b[0]) st_next.per_bak = st_reg.sil_bak + 8'h01;
    end
    // Lost flags rise after two silent periods and clear on the next falling edge
    // No flag before a period is known: the reset period is only a guess, and a limit
    // below the real period would flag a live clock just after reset
    st_next.lost_p = (st_reg.sil_pri >= lost_lim_p) & ~pri_fall & st_reg.cal_p[1];
    st_next.lost_b = (st_reg.sil_bak >= lost_lim_b) & ~bak_fall & st_reg.cal_b[1];

    // Request hold qualification
    // The hold count runs in system cycles against measured reference periods,
    // so it tracks whichever input is slower without a second clock domain
    if (!st_reg.s_req[1]) begin
      st_next.req_armed = 1'b0;
      st_next.req_used  = 1'b0;
      st_next.hold_cnt  = 8'h00;
    end else if (req_rise) begin
      st_next.req_armed = 1'b1;
      st_next.hold_cnt  = 8'h01;
    end else if (st_reg.req_armed && st_reg.hold_cnt != 8'hff) begin
      st_next.hold_cnt = st_reg.hold_cnt + 8'h01;
    end

    // Decide whether a swap is wanted
    unique case (prs_pkg::prs_mode_e'(st_reg.mode))
      prs_pkg::PRS_MODE_MANUAL: begin
        want = st_reg.req_armed & ~st_reg.req_used & (st_reg.hold_cnt >= hold_lim);
      end
      prs_pkg::PRS_MODE_OVERRIDE: begin
        // One swap per rising request edge; a falling edge leaves the selection alone
        want = st_reg.req_armed & ~st_reg.req_used;
        auto_ok = ~st_reg.s_req[1];
      end
      default: auto_ok = 1'b1;
    endcase
    // Auto swap only when current reference is lost and the other is alive
    if (auto_ok && (st_reg.sel ? st_reg.lost_b : st_reg.lost_p)
        && !(st_reg.lost_p && st_reg.lost_b))
      want = 1'b1;

    // Switch sequence
    st_next.rst_hint = 1'b0;
    unique case (st_reg.st)
      prs_pkg::PRS_ST_RUN: begin
        if (want) begin
          st_next.st = prs_pkg::PRS_ST_GATE;
          // Mark the request level as spent so it cannot start a second swap
          if (st_reg.req_armed) st_next.req_used = 1'b1;
        end
      end
      prs_pkg::PRS_ST_GATE: begin
        // Gate the divider reference on the old input falling edge, or at once if it is dead
        if ((st_reg.sel ? bak_fall : pri_fall) || (st_reg.sel ? st_reg.lost_b : st_reg.lost_p)) begin
          st_next.gate = 1'b1;
          st_next.st   = prs_pkg::PRS_ST_MOVE;
        end
      end
      prs_pkg::PRS_ST_MOVE: begin
        // Wait for the target to toggle, then move on its falling edge
        // While the target is silent the machine parks here with the gate shut;
        // the PLL then sees no reference, the price of never moving to a dead input
        if (tgt_ok && (st_reg.sel ? pri_fall : bak_fall)) begin
          st_next.sel      = ~st_reg.sel;
          st_next.gate     = 1'b0;
          st_next.rst_hint = 1'b1;
          st_next.st       = prs_pkg::PRS_ST_RUN;
        end
      end
      default: st_next.st = prs_pkg::PRS_ST_RUN;
    endcase

    // Output dividers take pending values at their own count boundary
    // Waiting for the wrap keeps any output from seeing a period made
    // half of the old count and half of the new one
    for (int i = 0; i < prs_pkg::PRS_N_OUT; i++) begin
      if (st_reg.cnt[i*DW +: DW] >= st_reg.out_div[i*DW +: DW]) begin
        st_next.cnt[i*DW +: DW] = '0;
        if (st_reg.pend[i]) begin
          st_next.out_div[i*DW +: DW] = st_reg.pend_div[i*DW +: DW];
          st_next.pend[i] = 1'b0;
        end
      end else begin
        st_next.cnt[i*DW +: DW] = st_reg.cnt[i*DW +: DW] + 9'h001;
      end
    end

    // Register writes
    // Each write to the scan address is one scan clock, so the rate never passes the system clock
    if (reg_wr) begin
      unique case (reg_addr)
        prs_pkg::PRS_ADDR_CTRL: begin
          st_next.mode = reg_wdata[1:0];
          if (reg_wdata[prs_pkg::PRS_CTRL_APPLY_BIT]) begin
            // Copy the chain to active settings, output dividers to pending, cascade mask untouched
            {st_next.pre_div, st_next.fb_div, st_next.pend_div, st_next.pump,
             st_next.filt_r, st_next.filt_c} = st_reg.scan;
            // The chain carries output 0 first, so it sits above output 4 in the
            // shifted word; put each field in its own slot, output 0 lowest
            for (int i = 0; i < prs_pkg::PRS_N_OUT; i++)
              st_next.pend_div[i*DW +: DW] = st_reg.scan[SCAN_LEN-1-(2+i)*DW -: DW];
            st_next.pend = 5'h1f;
          end
        end
        prs_pkg::PRS_ADDR_SCAN: st_next.scan = {st_reg.scan[SCAN_LEN-2:0], reg_wdata[0]};
        default: ;
      endcase
    end

    // Register reads, answer in the next cycle
    // Unmapped addresses and idle cycles read as zero
    st_next.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        prs_pkg::PRS_ADDR_CTRL:   st_next.rdata = {30'h0, st_reg.mode};
        prs_pkg::PRS_ADDR_STATUS: st_next.rdata = {27'h0, st_reg.st == prs_pkg::PRS_ST_MOVE && !tgt_ok,
                                                   st_reg.st != prs_pkg::PRS_ST_RUN,
                                                   st_reg.lost_b, st_reg.lost_p, st_reg.sel};
        prs_pkg::PRS_ADDR_PRE:    st_next.rdata = 32'(st_reg.pre_div);
        prs_pkg::PRS_ADDR_FB:     st_next.rdata = 32'(st_reg.fb_div);
        prs_pkg::PRS_ADDR_PUMP:   st_next.rdata = 32'(st_reg.pump);
        prs_pkg::PRS_ADDR_FILT:   st_next.rdata = {16'h0, st_reg.filt_c, st_reg.filt_r};
        prs_pkg::PRS_ADDR_CHAIN:  st_next.rdata = {27'h0, CASCADE_MASK};
        default: begin
          if (reg_addr >= prs_pkg::PRS_ADDR_OUT0 && reg_addr < prs_pkg::PRS_ADDR_PUMP)
            st_next.rdata = 32'(st_reg.out_div[DW*(32'(reg_addr) - 32'(prs_pkg::PRS_ADDR_OUT0)) +: DW]);
        end
      endcase
    end

    // Mode change while manual forces the primary at start only through reset
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset leaves both lost flags low and the primary selected, which is also
  // the start of manual mode; periods must be measured again after it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg         <= '0;
      st_reg.mode    <= prs_pkg::PRS_MODE_RESET;
      st_reg.st      <= prs_pkg::PRS_ST_RUN;
      st_reg.per_pri <= prs_pkg::PRS_REF_PERIOD_RESET;
      st_reg.per_bak <= prs_pkg::PRS_REF_PERIOD_RESET;
      st_reg.out_div <= {prs_pkg::PRS_N_OUT{9'h001}};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state, cascade_out straight from CASCADE_MASK
  // No logic between the state register and the pins, so nothing glitches
  always_comb begin
    reg_rdata       = st_reg.rdata;
    in_use          = st_reg.sel;
    lost_primary    = st_reg.lost_p;
    lost_backup     = st_reg.lost_b;
    mux_gate        = st_reg.gate;
    pll_reset_hint  = st_reg.rst_hint;
    output_dividers = st_reg.out_div;
    cascade_out     = CASCADE_MASK;
  end
endmodule

//--- dv/prs_ref_model.sv
// Two reference clock sources with run controls
`timescale 1ns/1ns
module prs_ref_model #(
  parameter int HALF_P = 40,
  parameter int HALF_B = 44
) (
  input  wire logic run_p,
  input  wire logic run_b,
  output logic      ref_p,
  output logic      ref_b
);
  // ****************************************
  // Clock sources
  // ****************************************
  // Periods 80 ns and 88 ns stay within 20% of each other
  // A stopped source parks low, as a dead oscillator does
  initial begin
    ref_p = 1'b0;
    forever begin
      #HALF_P;
      ref_p = run_p ? ~ref_p : 1'b0;
    end
  end
  // Backup source, free running apart from the primary
  initial begin
    ref_b = 1'b0;
    forever begin
      #HALF_B;
      ref_b = run_b ? ~ref_b : 1'b0;
    end
  end
endmodule

//--- dv/prs_ref_switch_monitor.sv
// Port checker for the reference switchover block
`timescale 1ns/1ns
module prs_ref_switch_checker #(
  parameter logic [4:0] CASCADE_MASK = 5'h00
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        ref_clk_primary,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        in_use,
  input wire logic        lost_primary,
  input wire logic        lost_backup,
  input wire logic        mux_gate,
  input wire logic        pll_reset_hint,
  input wire logic [4:0]  cascade_out
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] quiet_reg;
  logic       last_reg;
  // Cycles since the primary reference last changed level
  always_ff @(posedge sys_clk) begin
    last_reg <= ref_clk_primary;
    if (reset || ref_clk_primary != last_reg) quiet_reg <= 8'h00;
    else if (quiet_reg != 8'hff) quiet_reg <= quiet_reg + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_flip;
    $changed(in_use);
  endsequence
  sequence s_gated;
    $past(mux_gate);
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_cascade_fixed: assert property (cascade_out == CASCADE_MASK)
    else $error("cascade mask changed");
  a_hint_single: assert property (pll_reset_hint |=> !pll_reset_hint)
    else $error("reset hint longer than one cycle");
  a_flip_hint: assert property (s_flip |-> pll_reset_hint)
    else $error("selection changed without completion pulse");
  a_gate_first: assert property (s_flip |-> s_gated)
    else $error("selection changed without gating first");
  a_dead_hold: assert property (lost_primary && lost_backup |=> $stable(in_use))
    else $error("switch while both references dead");
  a_lost_silent: assert property ($rose(lost_primary) |-> quiet_reg >= 8'd4)
    else $error("primary lost flag on a live clock");
  a_gate_bounded: assert property ($rose(mux_gate) |-> ##[1:600] !mux_gate)
    else $error("gate held too long");
  c_flip: cover property (s_flip);
endmodule
bind prs_ref_switch prs_ref_switch_checker #(.CASCADE_MASK(CASCADE_MASK)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .ref_clk_primary(ref_clk_primary), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .in_use(in_use), .lost_primary(lost_primary), .lost_backup(lost_backup),
  .mux_gate(mux_gate), .pll_reset_hint(pll_reset_hint), .cascade_out(cascade_out));

//--- dv/testbench.sv
// Self-checking bench for the reference switchover block
`timescale 1ns/1ns
module testbench;
  logic        sys_clk, reset, run_p, run_b, ref_p, ref_b, switch_req, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        in_use, lost_primary, lost_backup, mux_gate, pll_reset_hint;
  logic [44:0] output_dividers;
  logic [4:0]  cascade_out;
  int          num_errors, n_compared;
  prs_ref_model u_src (.run_p(run_p), .run_b(run_b), .ref_p(ref_p), .ref_b(ref_b));
  prs_ref_switch #(.CASCADE_MASK(5'h03)) dut (
    .sys_clk(sys_clk), .reset(reset), .ref_clk_primary(ref_p), .ref_clk_backup(ref_b),
    .switch_req(switch_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_use(in_use), .lost_primary(lost_primary),
    .lost_backup(lost_backup), .mux_gate(mux_gate), .pll_reset_hint(pll_reset_hint),
    .output_dividers(output_dividers), .cascade_out(cascade_out));
  // Clock at 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task wrap_up;
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [44:0] got, input logic [44:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task do_reset;
    @(posedge sys_clk);
    reset <= 1'b1;
    idle(6);
    reset <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input string w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({13'h0, reg_rdata}, {13'h0, e}, w);
  endtask
  // Bounded wait for in_use (0), lost_primary (1) or lost_backup (2)
  task wait_bit(input int s, input logic v);
    logic b;
    for (int i = 0; i < 600; i++) begin
      @(posedge sys_clk);
      #1;
      b = (s == 0) ? in_use : (s == 1) ? lost_primary : lost_backup;
      if (b === v) return;
    end
    num_errors++;
    $display("BAD %0t wait ran out on %0d", $time, s);
    wrap_up();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_scan;
    logic [81:0] v;
    v = {9'h002, 9'h010, 9'h003, 9'h004, 9'h005, 9'h006, 9'h007, 3'h5, 8'h5a, 8'ha5};
    do_reset();
    chk(output_dividers, {5{9'h001}}, "dividers after reset");
    rd(prs_pkg::PRS_ADDR_STATUS, 32'h0, "status after reset");
    rd(4'hd, 32'h0, "unmapped read");
    for (int i = 81; i >= 0; i--) wr(prs_pkg::PRS_ADDR_SCAN, {31'h0, v[i]});
    wr(prs_pkg::PRS_ADDR_CTRL, 32'h4);
    idle(300);
    chk(output_dividers, {9'h007, 9'h006, 9'h005, 9'h004, 9'h003}, "output dividers");
    rd(prs_pkg::PRS_ADDR_PRE, 32'h2, "pre divider");
    rd(prs_pkg::PRS_ADDR_FB, 32'h10, "feedback divider");
    rd(prs_pkg::PRS_ADDR_PUMP, 32'h5, "pump current");
    rd(prs_pkg::PRS_ADDR_FILT, 32'ha55a, "loop filter");
    rd(prs_pkg::PRS_ADDR_CHAIN, 32'h3, "cascade mask");
    chk({40'h0, cascade_out}, 45'h3, "cascade out");
    $display("done scan");
  endtask
  task t_auto;
    do_reset();
    idle(40);
    run_p <= 1'b0;
    wait_bit(1, 1'b1);
    wait_bit(0, 1'b1);
    chk({44'h0, lost_backup}, 45'h0, "backup flag on live clock");
    run_p <= 1'b1;
    wait_bit(1, 1'b0);
    run_p <= 1'b0;
    run_b <= 1'b0;
    idle(200);
    chk({44'h0, in_use}, 45'h1, "switch with both dead");
    run_p <= 1'b1;
    run_b <= 1'b1;
    wait_bit(2, 1'b0);
    $display("done auto");
  endtask
  task t_override;
    do_reset();
    wr(prs_pkg::PRS_ADDR_CTRL, 32'h1);
    switch_req <= 1'b1;
    wait_bit(0, 1'b1);
    chk({43'h0, lost_primary, lost_backup}, 45'h0, "lost flag in commanded switch");
    switch_req <= 1'b0;
    idle(100);
    chk({44'h0, in_use}, 45'h1, "falling request swapped");
    switch_req <= 1'b1;
    wait_bit(0, 1'b0);
    run_p <= 1'b0;
    idle(100);
    chk({44'h0, in_use}, 45'h0, "auto switch while request high");
    run_p <= 1'b1;
    switch_req <= 1'b0;
    $display("done override");
  endtask
  task t_wait;
    do_reset();
    idle(40);
    wr(prs_pkg::PRS_ADDR_CTRL, 32'h1);
    run_b <= 1'b0;
    wait_bit(2, 1'b1);
    switch_req <= 1'b1;
    idle(150);
    chk({44'h0, in_use}, 45'h0, "switch to dead target");
    run_b <= 1'b1;
    wait_bit(0, 1'b1);
    switch_req <= 1'b0;
    $display("done wait");
  endtask
  task t_manual;
    do_reset();
    wr(prs_pkg::PRS_ADDR_CTRL, 32'h2);
    idle(20);
    chk({44'h0, in_use}, 45'h0, "manual start");
    switch_req <= 1'b1;
    idle(8);
    switch_req <= 1'b0;
    idle(80);
    chk({44'h0, in_use}, 45'h0, "short request swapped");
    switch_req <= 1'b1; // Held past three slow periods and left high
    wait_bit(0, 1'b1);
    $display("done manual");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reset, switch_req, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {run_p, run_b} = 2'b11;
    num_errors = 0;
    n_compared = 0;
    t_scan();
    t_auto();
    t_override();
    t_wait();
    t_manual();
    wrap_up();
  end
endmodule
